// ### verilog/serial_slave_pkg.sv
/*
 * Shared constants, types and helpers for the serial command/data slave.
 * Assumes a 100 MHz reference clock and a host paced by the request flag.
 */
// Operation
// - first strobe-high sampling edge starts a byte
// - strobe high at last bit continues reception
// - passive mode: bits only while strobe high
// - command is opcode, address, then 16-bit words
// - command bits sampled on rising serial edge
// - command fields travel most significant bit first
// - select held low; clock pauses are tolerated
// - only read and write opcodes are supported
// - request drops after every read command and every written word
// - read ignores input and shifts register out
// - read drops request only briefly
// - write holds request low during update
// - multiple words may follow one write
// - request drops after each written word
// - shared select rising edge frames data bytes
// - commands may sit between data bytes
// - native mode takes back-to-back bytes
// - shared data select is inverted command select
// - request high means room for more
// - serial output floats outside reads
package serial_slave_pkg;

    // ****************************************************************
    // command channel encoding
    // ****************************************************************
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [3:0] LAST_BYTE_BIT = 4'h7;
    localparam logic [3:0] LAST_WORD_BIT = 4'hF;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    localparam int REG_ADDR_W = 4;
    localparam logic [7:0] CLOCK_REG_ADDR = 8'h03;

    // ****************************************************************
    // request flag timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int READ_LOW_TIME_NS = 50;
    localparam int WRITE_EXEC_TIME_NS = 200;
    localparam int CLOCK_EXEC_TIME_NS = 20000;
    localparam logic [15:0] READ_LOW_CYCLES =
        16'((READ_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] WRITE_EXEC_CYCLES =
        16'((WRITE_EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] CLOCK_EXEC_CYCLES =
        16'((CLOCK_EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ****************************************************************
    // state types
    // ****************************************************************
    typedef enum logic [2:0] {CMD_OPCODE, CMD_ADDR, CMD_WDATA, CMD_RDATA, CMD_IGNORE} cmd_phase_t;
    typedef enum logic [0:0] {LEG_IDLE, LEG_RX} leg_state_t;

    // insert one bit into a byte in the selected order
    function automatic logic [7:0] ins_bit(input logic [7:0] sh, input logic b,
                                           input logic lsb_first);
        ins_bit = lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction : ins_bit

endpackage : serial_slave_pkg

// ### verilog/link_word_store.sv
/*
 * Serial-clock side storage: control register array with registered read
 * data, plus toggles and held words announcing events to the other domain.
 * Assumes its inputs come from logic on the same serial clock.
 */
`timescale 1ns/1ps
module link_word_store
    import serial_slave_pkg::*;
(
    input wire logic serial_clock,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic byte_en,
    input wire logic [7:0] byte_in,
    output logic [15:0] rd_data,
    output logic wr_tgl,
    output logic rd_tgl,
    output logic byte_tgl,
    output logic [7:0] last_addr,
    output logic [15:0] last_data,
    output logic [7:0] last_byte
);

    typedef struct packed {
        logic [15:0] rdata;
        logic wr_tgl;
        logic rd_tgl;
        logic byte_tgl;
        logic [7:0] addr;
        logic [15:0] data;
        logic [7:0] byte_v;
    } store_t;

    store_t q, d;
    logic [15:0] mem [0:(1 << REG_ADDR_W) - 1];

    // ****************************************************************
    // event bookkeeping
    // ****************************************************************
    always_comb begin
        d = q;
        if (rd_en) begin
            d.rdata = mem[rd_addr[REG_ADDR_W-1:0]];
            d.rd_tgl = ~q.rd_tgl;
        end
        if (wr_en) begin
            d.wr_tgl = ~q.wr_tgl;
            d.addr = wr_addr;
            d.data = wr_data;
        end
        if (byte_en) begin
            d.byte_tgl = ~q.byte_tgl;
            d.byte_v = byte_in;
        end
    end

    always_ff @(posedge serial_clock or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // register array, no reset
    always_ff @(posedge serial_clock) begin
        if (wr_en) begin
            mem[wr_addr[REG_ADDR_W-1:0]] <= wr_data;
        end
    end

    assign rd_data = q.rdata;
    assign wr_tgl = q.wr_tgl;
    assign rd_tgl = q.rd_tgl;
    assign byte_tgl = q.byte_tgl;
    assign last_addr = q.addr;
    assign last_data = q.data;
    assign last_byte = q.byte_v;

endmodule : link_word_store

// ### verilog/serial_command_data_slave.sv
/*
 * Slave front end: command channel (register read/write) and data channel
 * (byte stream, native or legacy framing), with the request flag.
 * Assumes the serial clock comes from the host, the legacy data pins are
 * asynchronous, and the mode bits change only while the link is idle.
 */
`timescale 1ns/1ps
module serial_command_data_slave
    import serial_slave_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic serial_clock,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe_n,
    input wire logic command_select_n,
    input wire logic data_select_n,
    input wire logic byte_sync_strobe,
    input wire logic legacy_data_clock,
    input wire logic legacy_data_in,
    input wire logic native_pins_bit,
    input wire logic native_mode_bit,
    input wire logic shared_select_bit,
    input wire logic lsb_first_bit,
    input wire logic falling_sample_bit,
    input wire logic stream_room_ok,
    output logic request,
    output logic [7:0] stream_byte,
    output logic stream_valid,
    output logic reg_write,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_data
);

    // ****************************************************************
    // state types
    // ****************************************************************
    typedef struct packed {
        cmd_phase_t phase;
        logic [3:0] cnt;
        logic [15:0] shift;
        logic is_read;
        logic [7:0] addr;
    } cmd_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] shift;
    } dat_t;

    typedef struct packed {
        logic [2:0] lclk_s;
        logic [2:0] ldat_s;
        logic [2:0] sync_s;
        logic [2:0] wr_s;
        logic [2:0] rd_s;
        logic [2:0] by_s;
        leg_state_t leg_state;
        logic [2:0] leg_cnt;
        logic [7:0] leg_shift;
        logic [15:0] busy;
        logic [7:0] byte_q;
        logic byte_valid;
        logic reg_we;
        logic [7:0] addr_q;
        logic [15:0] data_q;
    } ref_t;

    cmd_t cq, cd;
    dat_t dq, dd;
    ref_t rq, rd;

    logic cmd_arst, data_sel_n, dat_arst;
    logic wr_en, rd_en, byte_en;
    logic [7:0] byte_in;
    logic [15:0] st_rdata, st_data;
    logic [7:0] st_addr, st_byte;
    logic st_wr_tgl, st_rd_tgl, st_by_tgl;

    // duration of a register update, by register and value
    function automatic logic [15:0] exec_cycles(input logic [7:0] a, input logic [15:0] v);
        if (a == CLOCK_REG_ADDR && v != 16'h0000) begin
            exec_cycles = CLOCK_EXEC_CYCLES;
        end else begin
            exec_cycles = WRITE_EXEC_CYCLES;
        end
    endfunction : exec_cycles

    // ****************************************************************
    // channel framing selects
    // ****************************************************************
    assign cmd_arst = rst | command_select_n;
    assign data_sel_n = shared_select_bit ? ~command_select_n : data_select_n;
    assign dat_arst = rst | data_sel_n;

    // ****************************************************************
    // command channel, serial clock domain
    // ****************************************************************
    always_comb begin
        cd = cq;
        wr_en = 1'b0;
        rd_en = 1'b0;
        cd.shift = {cq.shift[14:0], serial_in};
        cd.cnt = cq.cnt + 4'h1;
        case (cq.phase)
            CMD_OPCODE: begin
                if (cq.cnt == LAST_BYTE_BIT) begin
                    cd.cnt = 4'h0;
                    cd.is_read = (cd.shift[7:0] == OP_READ);
                    if (cd.shift[7:0] == OP_READ || cd.shift[7:0] == OP_WRITE) begin
                        cd.phase = CMD_ADDR;
                    end else begin
                        cd.phase = CMD_IGNORE;
                    end
                end
            end
            CMD_ADDR: begin
                if (cq.cnt == LAST_BYTE_BIT) begin
                    cd.cnt = 4'h0;
                    cd.phase = cq.is_read ? CMD_RDATA : CMD_WDATA;
                    cd.addr = cd.shift[7:0];
                    rd_en = cq.is_read;
                end
            end
            CMD_WDATA: begin
                if (cq.cnt == LAST_WORD_BIT) begin
                    wr_en = 1'b1;
                    cd.cnt = 4'h0;
                end
            end
            CMD_RDATA: begin
                if (cq.cnt == LAST_WORD_BIT) begin
                    cd.phase = CMD_IGNORE;
                end
            end
            CMD_IGNORE: begin
                cd.cnt = cq.cnt;
            end
            default: begin
                cd.phase = CMD_IGNORE;
            end
        endcase
    end

    always_ff @(posedge serial_clock or posedge cmd_arst) begin
        if (cmd_arst) begin
            cq <= '0;
        end else begin
            cq <= cd;
        end
    end

    // read word leaves msb first, driven only during the read phase
    assign serial_out = st_rdata[4'hF - cq.cnt];
    assign serial_out_oe_n = (cq.phase != CMD_RDATA);

    // ****************************************************************
    // native data channel, serial clock domain
    // ****************************************************************
    always_comb begin
        dd = dq;
        dd.shift = ins_bit(dq.shift, serial_in, lsb_first_bit);
        dd.cnt = dq.cnt + 3'h1;
        byte_en = (dq.cnt == LAST_DATA_BIT);
        byte_in = dd.shift;
    end

    always_ff @(posedge serial_clock or posedge dat_arst) begin
        if (dat_arst) begin
            dq <= '0;
        end else begin
            dq <= dd;
        end
    end

    link_word_store store (
        .serial_clock(serial_clock),
        .rst(rst),
        .wr_en(wr_en),
        .wr_addr(cq.addr),
        .wr_data(cd.shift),
        .rd_en(rd_en),
        .rd_addr(cd.shift[7:0]),
        .byte_en(byte_en),
        .byte_in(byte_in),
        .rd_data(st_rdata),
        .wr_tgl(st_wr_tgl),
        .rd_tgl(st_rd_tgl),
        .byte_tgl(st_by_tgl),
        .last_addr(st_addr),
        .last_data(st_data),
        .last_byte(st_byte)
    );

    // ****************************************************************
    // reference clock domain: legacy receiver, events, request flag
    // ****************************************************************
    always_comb begin
        logic leg_en;
        logic passive;
        logic samp;
        logic strobe;
        logic bit_v;
        logic take;
        logic [7:0] nsh;
        logic wr_ev;
        logic rd_ev;
        logic by_ev;
        leg_en = 1'b0;
        passive = 1'b0;
        samp = 1'b0;
        strobe = 1'b0;
        bit_v = 1'b0;
        take = 1'b0;
        nsh = 8'h00;
        wr_ev = 1'b0;
        rd_ev = 1'b0;
        by_ev = 1'b0;
        rd = rq;
        rd.lclk_s = {rq.lclk_s[1:0], legacy_data_clock};
        rd.ldat_s = {rq.ldat_s[1:0], legacy_data_in};
        rd.sync_s = {rq.sync_s[1:0], byte_sync_strobe};
        rd.wr_s = {rq.wr_s[1:0], st_wr_tgl};
        rd.rd_s = {rq.rd_s[1:0], st_rd_tgl};
        rd.by_s = {rq.by_s[1:0], st_by_tgl};
        rd.byte_valid = 1'b0;
        rd.reg_we = 1'b0;
        passive = !native_mode_bit && shared_select_bit;
        leg_en = !native_pins_bit || passive;
        samp = falling_sample_bit ? (!rq.lclk_s[1] && rq.lclk_s[2])
                                  : (rq.lclk_s[1] && !rq.lclk_s[2]);
        strobe = rq.sync_s[1];
        bit_v = rq.ldat_s[1];
        wr_ev = rq.wr_s[1] ^ rq.wr_s[2];
        rd_ev = rq.rd_s[1] ^ rq.rd_s[2];
        by_ev = rq.by_s[1] ^ rq.by_s[2];
        // legacy and passive byte framing
        if (!leg_en) begin
            rd.leg_state = LEG_IDLE;
            rd.leg_cnt = 3'h0;
        end else if (passive && strobe && !rq.sync_s[2]) begin
            rd.leg_state = LEG_RX;
            rd.leg_cnt = 3'h0;
        end else if (samp) begin
            case (rq.leg_state)
                LEG_IDLE: take = strobe && !passive;
                LEG_RX: take = !passive || strobe;
                default: take = 1'b0;
            endcase
            if (take) begin
                nsh = ins_bit(rq.leg_shift, bit_v, lsb_first_bit);
                rd.leg_shift = nsh;
                rd.leg_state = LEG_RX;
                rd.leg_cnt = rq.leg_cnt + 3'h1;
                if (rq.leg_state == LEG_RX && rq.leg_cnt == LAST_DATA_BIT) begin
                    rd.byte_q = nsh;
                    rd.byte_valid = 1'b1;
                    rd.leg_cnt = 3'h0;
                    rd.leg_state = strobe ? LEG_RX : LEG_IDLE;
                end else if (rq.leg_state == LEG_IDLE) begin
                    rd.leg_cnt = 3'h1;
                end
            end
        end
        // native bytes delivered from the serial domain
        if (by_ev && !leg_en) begin
            rd.byte_q = st_byte;
            rd.byte_valid = 1'b1;
        end
        // request flag hold-off
        if (rq.busy != 16'h0000) begin
            rd.busy = rq.busy - 16'h0001;
        end
        if (rd_ev) begin
            rd.busy = READ_LOW_CYCLES;
        end
        if (wr_ev) begin
            rd.busy = exec_cycles(st_addr, st_data);
            rd.reg_we = 1'b1;
            rd.addr_q = st_addr;
            rd.data_q = st_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rq <= '0;
        end else begin
            rq <= rd;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign request = (rq.busy == 16'h0000) && stream_room_ok;
    assign stream_byte = rq.byte_q;
    assign stream_valid = rq.byte_valid;
    assign reg_write = rq.reg_we;
    assign reg_addr = rq.addr_q;
    assign reg_data = rq.data_q;

endmodule : serial_command_data_slave

// ### verif/serial_slave_props.sv
/*
 * Checker: request pacing, result pulses, output enable.
 * Assumes binding to the top with ref_clk at 100 MHz.
 */
`timescale 1ns/1ps
module serial_slave_props
    import serial_slave_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic command_select_n,
    input wire logic serial_out_oe_n,
    input wire logic stream_room_ok,
    input wire logic request,
    input wire logic [7:0] stream_byte,
    input wire logic stream_valid,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_data
);
    // ****************************************************************
    // helper: request-low run length
    // ****************************************************************
    typedef struct packed {logic [11:0] low;} chk_state_t;
    chk_state_t s_q;
    chk_state_t s_d;
    // consecutive low cycles of request
    always_comb begin
        s_d = s_q;
        s_d.low = request ? 12'h000 : s_q.low + 12'h001;
    end
    // register the count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ****************************************************************
    // properties
    // ****************************************************************
    valid_pulse_a: assert property (stream_valid |=> !stream_valid)
        else $error("valid too long");
    write_pulse_a: assert property (reg_write |=> !reg_write)
        else $error("write too long");
    write_busy_a: assert property ($rose(reg_write) |-> ##[0:2] !request [*8])
        else $error("request up during update");
    room_gate_a: assert property (!stream_room_ok |-> !request)
        else $error("request without room");
    busy_bound_a: assert property (s_q.low <= CLOCK_EXEC_CYCLES[11:0] + 12'h002)
        else $error("request low too long");
    byte_hold_a: assert property (!stream_valid |-> $stable(stream_byte))
        else $error("byte moved");
    word_hold_a: assert property (!reg_write |-> $stable({reg_addr, reg_data}))
        else $error("word moved");
    oe_select_a: assert property (!serial_out_oe_n |-> !command_select_n)
        else $error("output on while deselected");
    abort_float_a: assert property ($rose(command_select_n) |-> serial_out_oe_n [*3])
        else $error("output on after deselect");
endmodule : serial_slave_props

bind serial_command_data_slave serial_slave_props u_props (.ref_clk(ref_clk), .rst(rst),
    .command_select_n(command_select_n), .serial_out_oe_n(serial_out_oe_n),
    .stream_room_ok(stream_room_ok), .request(request), .stream_byte(stream_byte),
    .stream_valid(stream_valid), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_data(reg_data));

// ### verif/host_model.sv
/*
 * Host side of the serial link: selects and a gated 30 ns serial clock.
 * Assumes the bench paces frames on the request flag.
 */
`timescale 1ns/1ps
module host_model (
    output logic serial_clock,
    output logic serial_in,
    output logic command_select_n,
    output logic data_select_n,
    input wire logic serial_out
);
    // idle: clock parked low, both selects high
    initial begin
        serial_clock = 1'b0;
        serial_in = 1'b0;
        command_select_n = 1'b1;
        data_select_n = 1'b1;
    end
    // select change with margins
    task automatic sel(input logic cmd_n, input logic dat_n);
        #17;
        command_select_n = cmd_n;
        data_select_n = dat_n;
        #20;
    endtask : sel
    // n low bits of v, msb first; read data taken before the rise
    task automatic shift(input logic [15:0] v, input int n, output logic [15:0] got);
        got = '0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = v[i];
            #14;
            got = {got[14:0], serial_out};
            #1 serial_clock = 1'b1;
            #15 serial_clock = 1'b0;
        end
        serial_in = ~v[0]; // no stale bit
    endtask : shift
endmodule : host_model

// ### verif/serial_command_data_slave_tb.sv
/*
 * Self-checking bench: queue model of bytes and words.
 * Assumes package, host model and checker compile first.
 */
`timescale 1ns/1ps
module serial_command_data_slave_tb
    import serial_slave_pkg::*;
;
    logic ref_clk, rst, serial_clock, serial_in, serial_out, serial_out_oe_n;
    logic command_select_n, data_select_n, byte_sync_strobe, legacy_data_clock, legacy_data_in;
    logic native_pins_bit, native_mode_bit, shared_select_bit, lsb_first_bit;
    logic falling_sample_bit, stream_room_ok, request, stream_valid, reg_write;
    logic [7:0] stream_byte, reg_addr, b;
    logic [15:0] reg_data, got;
    logic [15:0] regs[16];
    logic [7:0] exp_bytes[$];
    logic [23:0] exp_wr[$];
    logic [31:0] rng;
    int n_mismatch, n_compared, low_run, last_low;

    serial_command_data_slave uut (.ref_clk(ref_clk), .rst(rst), .serial_clock(serial_clock),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
        .command_select_n(command_select_n), .data_select_n(data_select_n),
        .byte_sync_strobe(byte_sync_strobe), .legacy_data_clock(legacy_data_clock),
        .legacy_data_in(legacy_data_in), .native_pins_bit(native_pins_bit),
        .native_mode_bit(native_mode_bit), .shared_select_bit(shared_select_bit),
        .lsb_first_bit(lsb_first_bit), .falling_sample_bit(falling_sample_bit),
        .stream_room_ok(stream_room_ok), .request(request), .stream_byte(stream_byte),
        .stream_valid(stream_valid), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_data(reg_data));
    host_model host (.serial_clock(serial_clock), .serial_in(serial_in),
        .command_select_n(command_select_n), .data_select_n(data_select_n),
        .serial_out(serial_out));

    // ****************************************************************
    // clock, helpers, result monitor
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    // request-low runs; result pulses against the model queues
    always @(posedge ref_clk) begin
        if (request === 1'b0) begin
            low_run++;
        end else if (low_run > 0) begin
            last_low = low_run;
            low_run = 0;
        end
        if (stream_valid === 1'b1) begin
            check("stream_byte", stream_byte, exp_bytes.size() ? exp_bytes.pop_front() : 'x);
        end
        if (reg_write === 1'b1) begin
            check("reg_word", {reg_addr, reg_data}, exp_wr.size() ? exp_wr.pop_front() : 'x);
        end
    end
    // bounded wait for request high
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (10) @(posedge ref_clk);
        while (request !== 1'b1) begin
            @(posedge ref_clk);
            n++;
            if (n > 2200) begin
                check("request_rise", request, 1'b1);
                stop_test();
            end
        end
        @(posedge ref_clk);
        #1;
    endtask : wait_idle
    // one write frame; several words make a multiple write
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d[$]);
        int e;
        host.sel(1'b0, host.data_select_n);
        host.shift({OP_WRITE, a}, 16, got);
        foreach (d[i]) begin
            last_low = 0;
            exp_wr.push_back({a, d[i]});
            regs[a[3:0]] = d[i];
            host.shift(d[i], 16, got);
            if (i == d.size() - 1) host.sel(1'b1, host.data_select_n);
            wait_idle();
            e = (a == CLOCK_REG_ADDR && d[i] != 0) ? CLOCK_EXEC_CYCLES : WRITE_EXEC_CYCLES;
            check("write_busy", 32'(last_low >= e && last_low <= e + 2), 1);
        end
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a);
        last_low = 0;
        host.sel(1'b0, host.data_select_n);
        host.shift({OP_READ, a}, 16, got);
        host.shift(16'(rnd()), 16, got);
        host.sel(1'b1, host.data_select_n);
        check("read_data", got, regs[a[3:0]]);
        wait_idle();
        check("read_busy", 32'(last_low >= READ_LOW_CYCLES && last_low <= READ_LOW_CYCLES + 2), 1);
    endtask : reg_rd
    // refused frame: header, nbits filler, deselect
    task automatic frame(input logic [15:0] hdr, input int nbits);
        host.sel(1'b0, host.data_select_n);
        host.shift(hdr, 16, got);
        host.shift(16'(rnd()), nbits, got);
        host.sel(1'b1, host.data_select_n);
        repeat (30) @(posedge ref_clk);
        check("refused", request, 1'b1);
    endtask : frame
    task automatic nat_bytes(input int n);
        for (int k = 0; k < n; k++) begin
            b = 8'(rnd());
            exp_bytes.push_back(b);
            host.shift(16'(lsb_first_bit ? 8'({<<{b}}) : b), 8, got);
        end
    endtask : nat_bytes
    // legacy bits, strobe from mask; first toggle samples
    task automatic leg_seq(input logic [7:0] v, input logic [7:0] mask);
        @(posedge ref_clk);
        #1;
        for (int i = 0; i < 8; i++) begin
            legacy_data_in = lsb_first_bit ? v[i] : v[7 - i];
            byte_sync_strobe = mask[i];
            #60 legacy_data_clock = ~legacy_data_clock;
            #60 legacy_data_clock = ~legacy_data_clock;
        end
        byte_sync_strobe = 1'b0;
        legacy_data_in = ~legacy_data_in;
    endtask : leg_seq
    task automatic drain(input string what);
        repeat (20) @(posedge ref_clk);
        $display("test %s done", what);
        check("bytes_left", exp_bytes.size(), 0);
    endtask : drain

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rng = 32'h543FC261;
        {n_mismatch, n_compared, low_run, last_low} = '0;
        {rst, stream_room_ok, native_pins_bit, native_mode_bit} = 4'hF;
        {byte_sync_strobe, legacy_data_clock, legacy_data_in, shared_select_bit} = 4'h0;
        {lsb_first_bit, falling_sample_bit} = 2'h0;
        repeat (5) @(posedge ref_clk);
        #1;
        check("reset_oe_n", serial_out_oe_n, 1'b1);
        rst = 1'b0;
        for (int k = 0; k < 4; k++) reg_wr({4'(rnd()), 4'(2 * k)}, '{16'(rnd())});
        for (int k = 0; k < 4; k++) reg_rd({4'(rnd()), 4'(2 * k)});
        reg_wr(8'h15, '{16'(rnd()), 16'(rnd()), 16'(rnd())});
        reg_rd(8'h15);
        reg_wr(CLOCK_REG_ADDR, '{16'h0000});
        reg_wr(CLOCK_REG_ADDR, '{16'h8000});
        reg_rd(CLOCK_REG_ADDR);
        reg_wr(8'h21, '{16'hA5C3});
        for (int k = 0; k < 4; k++) frame({8'(rnd()) & 8'hFC ^ 8'h01, 8'h21}, 16);
        frame({OP_WRITE, 8'h21}, 8);
        reg_rd(8'h21);
        $display("test registers done");
        host.sel(1'b1, 1'b0);
        nat_bytes(3);
        host.sel(1'b1, 1'b1);
        lsb_first_bit = 1'b1;
        host.sel(1'b1, 1'b0);
        nat_bytes(3);
        host.shift(16'h00A5, 4, got);
        host.sel(1'b1, 1'b1);
        host.sel(1'b1, 1'b0);
        nat_bytes(1);
        host.sel(1'b1, 1'b1);
        drain("native");
        shared_select_bit = 1'b1;
        host.sel(1'b0, 1'b1);
        host.sel(1'b1, 1'b1);
        nat_bytes(2);
        reg_wr(8'h02, '{16'(rnd())});
        nat_bytes(1);
        drain("shared");
        @(posedge ref_clk);
        #1 stream_room_ok = 1'b0;
        @(posedge ref_clk);
        #1 check("room", request, 1'b0);
        stream_room_ok = 1'b1;
        {native_pins_bit, shared_select_bit} = 2'b00;
        for (int f = 0; f < 2; f++) begin
            {falling_sample_bit, lsb_first_bit, legacy_data_clock} = {3{f[0]}};
            exp_bytes.push_back(8'h3C ^ 8'(f));
            exp_bytes.push_back(8'hD1);
            leg_seq(8'h3C ^ 8'(f), 8'h81);
            leg_seq(8'hD1, 8'h00);
            leg_seq(8'h77, 8'h00);
            drain("legacy");
        end
        {legacy_data_clock, native_mode_bit, shared_select_bit} = 3'b101;
        exp_bytes.push_back(8'h96);
        exp_bytes.push_back(8'h4B);
        leg_seq(8'h96, 8'hFF);
        leg_seq(8'hE8, 8'h0F);
        leg_seq(8'h4B, 8'hFF);
        drain("passive");
        stop_test();
    end
    // watchdog
    initial begin
        #500000;
        check("run_done", 0, 1);
        stop_test();
    end
endmodule : serial_command_data_slave_tb
